// *** logic/pmf_front.sv ***
// Management serial slave front end: two-wire link engine plus AHB-Lite registers.
// Assumes hclk and link_clk are unrelated; the link pins are open drain.
//
// How it works
// - Works at standard and fast link rates
// - Never holds the serial clock low
// - Extra clocked byte is the check byte
// - Stop after data accepts without check
// - Data values use the linear format
// - Fixed exponent per command, others refused
// - Direct format never accepted nor produced
// - Alert line asserted when attention requested
// - Acknowledge alert address only if alerting
// - Alert read returns own slave address
// - Status command reports the communication error flag only
// - Bus writes change working copy only
// - Store command commits settings to storage
// - Reference trim limited to -30..+10 percent
// - Sense resistance and overcurrent levels held
// - Any clock rate from 10 to 400 kHz
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module pmf_front (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic link_clk,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe,
	output logic alert_out,
	output logic alert_oe,
	input wire logic [6:0] slave_addr,
	output logic [15:0] ref_trim,
	output logic [15:0] sense_resistance_setting,
	output logic [15:0] overcurrent_warning_level,
	output logic [15:0] overcurrent_fault_level,
	output logic nvm_store
);
	// Write length (0..2) or read length (1..2) of a command; 3 means unsupported
	function automatic logic [1:0] cmd_len(input logic [7:0] c, input logic rd);
		case (c)
			pmf_pkg::C_CLEAR, pmf_pkg::C_STORE: cmd_len = rd ? 2'd3 : 2'd0;
			pmf_pkg::C_VMODE, pmf_pkg::C_STATUS: cmd_len = rd ? 2'd1 : 2'd3;
			pmf_pkg::C_TRIM, pmf_pkg::C_SENSE, pmf_pkg::C_OCF, pmf_pkg::C_OCW: cmd_len = 2'd2;
			default: cmd_len = 2'd3;
		endcase
	endfunction

	// ---------------- Link clock domain ----------------
	logic lrst_n; // Link reset, released on link_clk
	logic scl_s, sda_s, alert_s, lack_s; // Synchronised levels
	logic [6:0] addr_s; // Synchronised address strap
	logic scl_d, sda_d, alert_d; // Previous samples for edges
	logic ctrl_alert; // Software alert request (hclk)
	logic hack; // Handshake acknowledge (hclk)
	pmf_pkg::pmf_lst_t state; // Link engine state
	logic [3:0] bitcnt; // Bits of current byte
	logic [7:0] shreg; // Byte seen on the wire
	logic [2:0] nbytes; // Bytes after the address
	logic [7:0] cmd; // Command code
	logic [15:0] dat; // Received data word
	logic rd; // Read direction
	logic ara; // Alert response transfer
	logic sda_low; // Drive data low
	logic [7:0] txsh; // Bits left to send
	logic [1:0] txidx; // Index of byte to send
	logic busy; // Between start and stop
	logic [7:0] crc; // Running check value
	logic [15:0] trim_l, sense_l, ocw_l, ocf_l; // Working settings
	logic cml; // Communication error flag
	logic alert_pend; // Pending alert
	logic st_pend; // Store waiting to cross
	logic dirty; // Settings changed since last crossing
	logic mreq; // Handshake request toggle
	logic [15:0] m_trim, m_sense, m_ocw, m_ocf; // Mirror held for the crossing
	logic m_st; // Mirror carries a store
	logic [7:0] tx_byte; // Next byte to transmit
	logic [15:0] rd_word; // Word for the current read command

	// Reset release into the link domain
	pmf_sync2 #(.W(1)) u_lrst (
		.clk(link_clk),
		.rst_n(hresetn),
		.d(1'b1),
		.q(lrst_n)
	);

	// Pins and hclk levels pass two flip-flops first
	pmf_sync2 #(.W(11)) u_lsync (
		.clk(link_clk),
		.rst_n(lrst_n),
		.d({scl_in, sda_in, ctrl_alert, hack, slave_addr}),
		.q({scl_s, sda_s, alert_s, lack_s, addr_s})
	);

	// Check calculator
	pmf_crc_if crc_bus ();
	pmf_crc8 u_crc (
		.bus(crc_bus)
	);
	assign crc_bus.crc = crc;
	assign crc_bus.data = shreg;

	// Edge history of the synchronised lines
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			scl_d <= 1'b0;
			sda_d <= 1'b0;
			alert_d <= 1'b0;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			alert_d <= alert_s;
		end
	end

	// Purely edge driven, no timeouts, so any rate the oversampling sees works
	logic scl_rise, scl_fall, start, stop, arise;
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start = scl_s & scl_d & sda_d & ~sda_s;
	assign stop = scl_s & scl_d & ~sda_d & sda_s;
	assign arise = alert_s & ~alert_d;

	// Address decode including the alert response address
	logic ara_hit, addr_hit, last_bit;
	assign ara_hit = (shreg[7:1] == pmf_pkg::ARA) && shreg[0] && alert_pend;
	assign addr_hit = (shreg[7:1] == addr_s) || ara_hit;
	assign last_bit = (bitcnt == 4'h8);

	// Read data: linear words, mode byte and status
	always_comb begin
		case (cmd)
			pmf_pkg::C_VMODE: rd_word = {8'h00, pmf_pkg::VMODE_BYTE};
			pmf_pkg::C_STATUS: rd_word = {14'h0000, cml, 1'b0};
			pmf_pkg::C_TRIM: rd_word = trim_l;
			pmf_pkg::C_SENSE: rd_word = sense_l;
			pmf_pkg::C_OCW: rd_word = ocw_l;
			pmf_pkg::C_OCF: rd_word = ocf_l;
			default: rd_word = 16'hffff;
		endcase
	end

	// Byte selection for transmit: data, then check byte if clocked
	always_comb begin
		if (ara) begin
			tx_byte = (txidx == 2'h0) ? {addr_s, 1'b0} : crc;
		end else if ({1'b0, txidx} < {1'b0, cmd_len(cmd, 1'b1)}) begin
			tx_byte = txidx[0] ? rd_word[15:8] : rd_word[7:0];
		end else begin
			tx_byte = crc;
		end
	end

	// Link engine: sample on SCL rise, change data on SCL fall
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			state <= pmf_pkg::L_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			nbytes <= 3'h0;
			cmd <= 8'h00;
			dat <= 16'h0000;
			rd <= 1'b0;
			ara <= 1'b0;
			sda_low <= 1'b0;
			txsh <= 8'h00;
			txidx <= 2'h0;
			busy <= 1'b0;
		end else if (start) begin
			// Start or repeated start: command code is kept for reads
			state <= pmf_pkg::L_ADDR;
			bitcnt <= 4'h0;
			nbytes <= 3'h0;
			txidx <= 2'h0;
			ara <= 1'b0;
			sda_low <= 1'b0;
			busy <= 1'b1;
		end else if (stop) begin
			state <= pmf_pkg::L_IDLE;
			sda_low <= 1'b0;
			busy <= 1'b0;
		end else if (scl_rise) begin
			case (state)
				pmf_pkg::L_ADDR, pmf_pkg::L_RX, pmf_pkg::L_TX: begin
					shreg <= {shreg[6:0], sda_s};
					bitcnt <= bitcnt + 4'h1;
				end
				pmf_pkg::L_TACK: begin
					// Master not acknowledging ends the read
					if (sda_s) begin
						state <= pmf_pkg::L_SKIP;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state)
				pmf_pkg::L_ADDR: begin
					if (last_bit && addr_hit) begin
						state <= pmf_pkg::L_AACK;
						sda_low <= 1'b1;
						rd <= shreg[0];
						ara <= ara_hit;
					end else if (last_bit) begin
						state <= pmf_pkg::L_SKIP;
					end
				end
				pmf_pkg::L_AACK: begin
					bitcnt <= 4'h0;
					if (rd) begin
						state <= pmf_pkg::L_TX;
						sda_low <= ~tx_byte[7];
						txsh <= {tx_byte[6:0], 1'b0};
						txidx <= txidx + 2'h1;
					end else begin
						state <= pmf_pkg::L_RX;
						sda_low <= 1'b0;
					end
				end
				pmf_pkg::L_RX: begin
					if (last_bit) begin
						// Command, low byte, high byte, then check byte
						if (nbytes == 3'h0) begin
							cmd <= shreg;
						end
						if (nbytes == 3'h1) begin
							dat[7:0] <= shreg;
						end
						if (nbytes == 3'h2) begin
							dat[15:8] <= shreg;
						end
						if (nbytes < 3'h4) begin
							nbytes <= nbytes + 3'h1;
							state <= pmf_pkg::L_RACK;
							sda_low <= 1'b1;
						end else begin
							state <= pmf_pkg::L_SKIP;
						end
					end
				end
				pmf_pkg::L_RACK: begin
					state <= pmf_pkg::L_RX;
					bitcnt <= 4'h0;
					sda_low <= 1'b0;
				end
				pmf_pkg::L_TX: begin
					if (last_bit) begin
						state <= pmf_pkg::L_TACK;
						sda_low <= 1'b0;
					end else begin
						sda_low <= ~txsh[7];
						txsh <= {txsh[6:0], 1'b0};
					end
				end
				pmf_pkg::L_TACK: begin
					// Master acknowledged: send the next byte
					state <= pmf_pkg::L_TX;
					bitcnt <= 4'h0;
					sda_low <= ~tx_byte[7];
					txsh <= {tx_byte[6:0], 1'b0};
					txidx <= txidx + 2'h1;
				end
				default: begin
				end
			endcase
		end
	end

	// Running check over every byte of a transaction, reset at first start
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			crc <= 8'h00;
		end else if (start && !busy) begin
			crc <= 8'h00;
		end else if (scl_fall && last_bit && (state == pmf_pkg::L_ADDR || state == pmf_pkg::L_RX ||
				state == pmf_pkg::L_TX)) begin
			crc <= crc_bus.next;
		end
	end

	// Write completion checks at stop
	logic [1:0] wlen;
	logic wr_done, len_plain, len_pec, value_ok, commit, bad;
	assign wlen = cmd_len(cmd, 1'b0);
	assign wr_done = stop && (state == pmf_pkg::L_RX) && !rd && !ara && (nbytes != 3'h0);
	assign len_plain = (wlen != 2'd3) && (nbytes == {1'b0, wlen} + 3'h1);
	assign len_pec = (wlen != 2'd3) && (nbytes == {1'b0, wlen} + 3'h2) && (crc == 8'h00);
	always_comb begin
		case (cmd)
			pmf_pkg::C_TRIM: value_ok = ($signed(dat) >= pmf_pkg::TRIM_MIN) &&
				($signed(dat) <= pmf_pkg::TRIM_MAX);
			pmf_pkg::C_SENSE: value_ok = (dat[15:11] == pmf_pkg::EXP_SENSE);
			pmf_pkg::C_OCW, pmf_pkg::C_OCF: value_ok = (dat[15:11] == pmf_pkg::EXP_OC);
			default: value_ok = 1'b1;
		endcase
	end
	assign commit = wr_done && (len_plain || len_pec) && value_ok;
	assign bad = wr_done && !commit;

	// Working settings: only bus writes change them
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			trim_l <= pmf_pkg::RST_TRIM;
			sense_l <= pmf_pkg::RST_SENSE;
			ocw_l <= pmf_pkg::RST_OCW;
			ocf_l <= pmf_pkg::RST_OCF;
		end else if (commit) begin
			case (cmd)
				pmf_pkg::C_TRIM: trim_l <= dat;
				pmf_pkg::C_SENSE: sense_l <= dat;
				pmf_pkg::C_OCW: ocw_l <= dat;
				pmf_pkg::C_OCF: ocf_l <= dat;
				default: begin
				end
			endcase
		end
	end

	// Communication error: refused write sets, clear command clears
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			cml <= 1'b0;
		end else if (bad) begin
			cml <= 1'b1;
		end else if (commit && cmd == pmf_pkg::C_CLEAR) begin
			cml <= 1'b0;
		end
	end

	// Alert: a new request sets, a served alert response clears, set wins
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			alert_pend <= 1'b0;
		end else if (arise) begin
			alert_pend <= 1'b1;
		end else if (scl_fall && state == pmf_pkg::L_AACK && ara) begin
			alert_pend <= 1'b0;
		end
	end

	// Crossing to hclk: mirror loads only when the last request was acknowledged
	logic load;
	assign load = dirty && (mreq == lack_s);
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			dirty <= 1'b0;
			st_pend <= 1'b0;
			mreq <= 1'b0;
			m_st <= 1'b0;
			m_trim <= pmf_pkg::RST_TRIM;
			m_sense <= pmf_pkg::RST_SENSE;
			m_ocw <= pmf_pkg::RST_OCW;
			m_ocf <= pmf_pkg::RST_OCF;
		end else begin
			dirty <= commit | (dirty & ~load);
			st_pend <= (commit && cmd == pmf_pkg::C_STORE) | (st_pend & ~load);
			if (load) begin
				mreq <= ~mreq;
				m_st <= st_pend;
				m_trim <= trim_l;
				m_sense <= sense_l;
				m_ocw <= ocw_l;
				m_ocf <= ocf_l;
			end
		end
	end

	// Open-drain pins; the clock line is never driven
	assign scl_out = 1'b0;
	assign scl_oe = 1'b0;
	assign sda_out = 1'b0;
	assign sda_oe = sda_low;
	assign alert_out = 1'b0;
	assign alert_oe = alert_pend;

	// ---------------- hclk domain ----------------
	logic hreq_s; // Synchronised request toggle
	logic copy; // New mirror to take
	logic st_flag; // Sticky store-done status
	logic dp_wr; // Write data phase pending
	logic [7:0] dp_addr; // Write address
	pmf_sync2 #(.W(1)) u_hsync (
		.clk(hclk),
		.rst_n(hresetn),
		.d(mreq),
		.q(hreq_s)
	);
	assign copy = hreq_s ^ hack;

	// Snapshot of the settings for the regulation logic and storage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hack <= 1'b0;
			nvm_store <= 1'b0;
			ref_trim <= pmf_pkg::RST_TRIM;
			sense_resistance_setting <= pmf_pkg::RST_SENSE;
			overcurrent_warning_level <= pmf_pkg::RST_OCW;
			overcurrent_fault_level <= pmf_pkg::RST_OCF;
		end else begin
			nvm_store <= copy && m_st;
			if (copy) begin
				hack <= hreq_s;
				ref_trim <= m_trim;
				sense_resistance_setting <= m_sense;
				overcurrent_warning_level <= m_ocw;
				overcurrent_fault_level <= m_ocf;
			end
		end
	end

	// AHB-Lite: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr <= 1'b0;
			dp_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			dp_wr <= hsel && htrans[1] && hready && hwrite && (hsize == 3'b010);
			dp_addr <= haddr[7:0];
			hrdata <= 32'h0000_0000;
			if (hsel && htrans[1] && hready && !hwrite) begin
				case (haddr[7:0])
					pmf_pkg::A_CTRL: hrdata <= {31'h0, ctrl_alert};
					pmf_pkg::A_STAT: hrdata <= {31'h0, st_flag};
					pmf_pkg::A_TRIM: hrdata <= {16'h0, ref_trim};
					pmf_pkg::A_SENSE: hrdata <= {16'h0, sense_resistance_setting};
					pmf_pkg::A_OCW: hrdata <= {16'h0, overcurrent_warning_level};
					pmf_pkg::A_OCF: hrdata <= {16'h0, overcurrent_fault_level};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control write and store-done status, set wins over write-one-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_alert <= 1'b0;
			st_flag <= 1'b0;
		end else begin
			if (dp_wr && dp_addr == pmf_pkg::A_CTRL) begin
				ctrl_alert <= hwdata[pmf_pkg::CTRL_ALERT];
			end
			if (copy && m_st) begin
				st_flag <= 1'b1;
			end else if (dp_wr && dp_addr == pmf_pkg::A_STAT && hwdata[pmf_pkg::STAT_STORE]) begin
				st_flag <= 1'b0;
			end
		end
	end

	// ---------------- Checks ----------------
	a_no_stretch: assert property (@(posedge link_clk) disable iff (!lrst_n) !scl_oe)
		else $error("clock line driven");
	a_pec_reject: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(wr_done && !len_plain && crc != 8'h00 && cmd == pmf_pkg::C_OCF) |=> $stable(ocf_l))
		else $error("write with bad check byte applied");
	a_plain_accept: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(wr_done && len_plain && cmd == pmf_pkg::C_OCF && dat[15:11] == pmf_pkg::EXP_OC)
		|=> ocf_l == $past(dat))
		else $error("write without check byte not applied");
	a_store_flag: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(commit && cmd == pmf_pkg::C_STORE) |=> st_pend && dirty)
		else $error("store command lost");
	a_ara_quiet: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(scl_fall && state == pmf_pkg::L_ADDR && last_bit && shreg[7:1] == pmf_pkg::ARA &&
		shreg[7:1] != addr_s && !alert_pend) |=> !sda_low && state == pmf_pkg::L_SKIP)
		else $error("alert address acknowledged without alert");
	a_alert_pin: assert property (@(posedge link_clk) disable iff (!lrst_n)
		arise |=> alert_oe)
		else $error("alert request not driven");
	a_ara_addr: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(scl_fall && state == pmf_pkg::L_AACK && ara) |=> sda_low == !addr_s[6])
		else $error("alert response byte wrong");
	a_sense_exp: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(commit && cmd == pmf_pkg::C_SENSE) |-> dat[15:11] == pmf_pkg::EXP_SENSE)
		else $error("foreign exponent accepted");
	a_trim_range: assert property (@(posedge link_clk) disable iff (!lrst_n)
		$signed(trim_l) >= pmf_pkg::TRIM_MIN && $signed(trim_l) <= pmf_pkg::TRIM_MAX)
		else $error("trim out of range");
	a_store_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		nvm_store |-> $past(copy) && $past(m_st))
		else $error("storage written without store command");
	a_snap_take: assert property (@(posedge hclk) disable iff (!hresetn)
		copy |=> overcurrent_fault_level == $past(m_ocf) && !copy)
		else $error("snapshot not taken");
endmodule
`default_nettype wire

// *** include/pmf_pkg.sv ***
// Constants shared by the management serial front end and its helpers.
// Assumes a 32-bit AHB-Lite register bus and a two-wire link with a PEC byte.
package pmf_pkg;
	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_TRIM = 8'h08;
	localparam logic [7:0] A_SENSE = 8'h0c;
	localparam logic [7:0] A_OCW = 8'h10;
	localparam logic [7:0] A_OCF = 8'h14;
	// Field positions
	localparam int CTRL_ALERT = 0;
	localparam int STAT_STORE = 0;
	localparam int SB_CML = 1;
	// Command codes of the link protocol
	localparam logic [7:0] C_CLEAR = 8'h03;
	localparam logic [7:0] C_STORE = 8'h15;
	localparam logic [7:0] C_VMODE = 8'h20;
	localparam logic [7:0] C_TRIM = 8'h22;
	localparam logic [7:0] C_SENSE = 8'h38;
	localparam logic [7:0] C_OCF = 8'h46;
	localparam logic [7:0] C_OCW = 8'h4a;
	localparam logic [7:0] C_STATUS = 8'h78;
	// Alert response address and linear mode byte (exponent -9)
	localparam logic [6:0] ARA = 7'h0c;
	localparam logic [7:0] VMODE_BYTE = 8'h17;
	// Fixed exponents of the linear words
	localparam logic [4:0] EXP_SENSE = 5'h16;
	localparam logic [4:0] EXP_OC = 5'h1f;
	// Trim limits: -30 % and +10 % of the nominal reference in 2^-9 V steps
	localparam logic signed [15:0] TRIM_MIN = 16'shffa4;
	localparam logic signed [15:0] TRIM_MAX = 16'sh001e;
	// Reset values of the working settings
	localparam logic [15:0] RST_TRIM = 16'h0000;
	localparam logic [15:0] RST_SENSE = 16'hb200;
	localparam logic [15:0] RST_OCW = 16'hf828;
	localparam logic [15:0] RST_OCF = 16'hf830;
	// Packet error check polynomial x^8+x^2+x+1
	localparam logic [7:0] CRC_POLY = 8'h07;
	// Link state machine
	typedef enum logic [2:0] {L_IDLE, L_ADDR, L_AACK, L_RX, L_RACK, L_TX, L_TACK, L_SKIP} pmf_lst_t;
endpackage

// *** include/pmf_crc_if.sv ***
// Carrier between the link engine and its packet error check calculator.
// Assumes both ends sit in the link clock domain.
`timescale 1ns/1ps
`default_nettype none
interface pmf_crc_if;
	logic [7:0] crc; // Running check value
	logic [7:0] data; // Byte seen on the wire
	logic [7:0] next; // Check value after the byte
	modport calc(input crc, input data, output next);
	modport user(output crc, output data, input next);
endinterface
`default_nettype wire

// *** logic/pmf_sync2.sv ***
// Two flip-flop synchroniser for levels entering a clock domain.
// Assumes each bit is a level that is stable for several destination cycles.
`timescale 1ns/1ps
`default_nettype none
module pmf_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta; // First stage, read only by the second

	// First stage catches the asynchronous level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
		end else begin
			meta <= d;
		end
	end

	// Second stage feeds the logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// *** logic/pmf_crc8.sv ***
// Byte-wide packet error check step over the check polynomial.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module pmf_crc8 (
	pmf_crc_if.calc bus
);
	logic [7:0] c; // Working value

	// Eight shift steps, one per bit, most significant first
	always_comb begin
		c = bus.crc ^ bus.data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ pmf_pkg::CRC_POLY) : {c[6:0], 1'b0};
		end
		bus.next = c;
	end
endmodule
`default_nettype wire

// *** tb/pmf_host.sv ***
// Two-wire bus master model: pulls clock and data low or releases them.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module pmf_host (
	input wire logic link_clk,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low
);
	int h = 8; // Half bit period in link clocks
	// Lines released while idle, so the clock stands still between frames
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// Wait a number of link clocks
	task automatic w(input int n);
		repeat (n) @(posedge link_clk);
	endtask
	// Set both lines, then hold them for half a bit
	task automatic p(input logic c, input logic dl);
		scl_low <= c;
		sda_low <= dl;
		w(h);
	endtask
	// Start or repeated start: data falls while the clock is high
	task automatic start();
		p(1'b1, 1'b0);
		p(1'b0, 1'b0);
		p(1'b0, 1'b1);
		p(1'b1, 1'b1);
	endtask
	// Stop: data rises while the clock is high
	task automatic stop();
		p(1'b1, 1'b1);
		p(1'b0, 1'b1);
		p(1'b0, 1'b0);
	endtask
	// One bit; data changes only while the clock is low, sampled late in the high half
	task automatic bit1(input logic b, output logic r);
		sda_low <= ~b;
		w(h);
		scl_low <= 1'b0;
		w(h);
		r = sda;
		scl_low <= 1'b1;
		w(2);
	endtask
	// Byte out, then data released for the acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit1(d[i], r);
		bit1(1'b1, r);
		ack = ~r;
	endtask
	// Byte in; the last byte of a read is left unacknowledged
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit1(1'b1, d[i]);
		bit1(last, r);
	endtask
endmodule
`default_nettype wire

// *** tb/pmf_front_tb_top.sv ***
// Bench for the management serial front end: link writes, reads, alerts, commits.
// Assumes pull-ups on the link lines and one AHB-Lite slave on the bus.
`timescale 1ns/1ps
`default_nettype none
module pmf_front_tb_top;
	typedef struct packed {
		logic [7:0] cmd; // Command code
		logic [15:0] val; // Word written
		logic [1:0] pec; // 0 none, 1 good, 2 bad check byte
		logic [7:0] adr; // Register mirroring the setting
		logic [15:0] exp; // Value expected afterwards
	} pmf_row_t;
	localparam logic [6:0] SADDR = 7'h2a; // Slave address strap
	logic hclk = 1'b0;
	logic link_clk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic hready, hresp, scl_out, scl_oe, sda_out, sda_oe, alert_out, alert_oe, nvm_store;
	logic [31:0] hrdata;
	logic [15:0] trim, sense, ocw, ocf;
	logic scl_low, sda_low;
	wire logic scl = ~(scl_low | (scl_oe & ~scl_out)); // Open drain, pulled up
	wire logic sda = ~(sda_low | (sda_oe & ~sda_out));
	wire logic alert_n = ~(alert_oe & ~alert_out);
	int n_mismatch = 0;
	int n_checks = 0;
	int n_store = 0; // Commit pulses seen
	int n_str = 0; // Link clocks with the clock pin driven
	logic [31:0] r;
	logic [7:0] d;
	logic ack;
	logic [31:0] dflt [4] = '{32'h0, 32'hb200, 32'hf828, 32'hf830};
	pmf_row_t rows [10] = '{'{8'h46, 16'hf840, 2'h0, 8'h14, 16'hf840},
		'{8'h4a, 16'hf820, 2'h1, 8'h10, 16'hf820}, '{8'h38, 16'hb180, 2'h0, 8'h0c, 16'hb180},
		'{8'h22, 16'h001e, 2'h0, 8'h08, 16'h001e}, '{8'h22, 16'hffa4, 2'h1, 8'h08, 16'hffa4},
		'{8'h22, 16'h001f, 2'h0, 8'h08, 16'hffa4}, '{8'h22, 16'hffa3, 2'h0, 8'h08, 16'hffa4},
		'{8'h46, 16'h0840, 2'h0, 8'h14, 16'hf840}, '{8'h4a, 16'hf830, 2'h2, 8'h10, 16'hf820},
		'{8'h46, 16'hf850, 2'h2, 8'h14, 16'hf840}};
	pmf_front dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
		.scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
		.sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .slave_addr(SADDR),
		.ref_trim(trim), .sense_resistance_setting(sense), .overcurrent_warning_level(ocw),
		.overcurrent_fault_level(ocf), .nvm_store(nvm_store));
	pmf_host host (.link_clk(link_clk), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One AHB-Lite single transfer; read data lands in r
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	// Check byte step, polynomial x^8+x^2+x+1
	function automatic logic [7:0] c8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] x;
		x = c ^ b;
		for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
		return x;
	endfunction
	// Link write of nb data bytes, low byte first, with an optional check byte
	task automatic lwr(input logic [7:0] cmd, input logic [15:0] v, input int nb, input int pec);
		logic [7:0] b [4];
		logic [7:0] c;
		b = '{{SADDR, 1'b0}, cmd, v[7:0], v[15:8]};
		c = 8'h00;
		host.start();
		for (int i = 0; i < nb + 2; i++) begin
			c = c8(c, b[i]);
			host.wbyte(b[i], ack);
			chk("byte ack", 32'(ack), 1);
		end
		if (pec != 0) host.wbyte(c ^ ((pec == 2) ? 8'h01 : 8'h00), ack);
		host.stop();
		repeat (30) @(posedge hclk);
	endtask
	// Link read of one byte after a command
	task automatic lrd(input logic [7:0] cmd);
		host.start();
		host.wbyte({SADDR, 1'b0}, ack);
		host.wbyte(cmd, ack);
		host.start();
		host.wbyte({SADDR, 1'b1}, ack);
		host.rbyte(1'b1, d);
		host.stop();
	endtask
	// Receive byte at the alert response address
	task automatic ara();
		host.start();
		host.wbyte({pmf_pkg::ARA, 1'b1}, ack);
		if (ack === 1'b1) host.rbyte(1'b1, d);
		host.stop();
		repeat (10) @(posedge link_clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial forever #10 hclk = ~hclk;
	initial begin
		#7;
		forever #15 link_clk = ~link_clk;
	end
	// Count commit pulses and any drive of the clock pin
	always @(posedge hclk) if (nvm_store === 1'b1) n_store++;
	always @(posedge link_clk) if (scl_oe !== 1'b0) n_str++;
	initial begin
		#1500000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (20) @(posedge hclk);
		foreach (rows[i]) begin
			lwr(rows[i].cmd, rows[i].val, 2, rows[i].pec);
			ahb(1'b0, {24'h0, rows[i].adr}, 32'h0);
			chk("setting", r, {16'h0, rows[i].exp});
		end
		chk("fault pin", 32'(ocf), 32'hf840);
		chk("warning pin", 32'(ocw), 32'hf820);
		chk("trim pin", 32'(trim), 32'hffa4);
		chk("sense pin", 32'(sense), 32'hb180);
		chk("no commit", n_store, 0);
		lrd(pmf_pkg::C_VMODE);
		chk("mode byte", 32'(d), 32'h17);
		lrd(pmf_pkg::C_STATUS);
		chk("status", 32'(d), 32'h02);
		lrd(pmf_pkg::C_OCF);
		chk("linear low byte", 32'(d), 32'h40);
		lwr(pmf_pkg::C_CLEAR, 16'h0, 0, 0);
		lrd(pmf_pkg::C_STATUS);
		chk("status cleared", 32'(d), 32'h00);
		lwr(pmf_pkg::C_STORE, 16'h0, 0, 1);
		chk("commit", n_store, 1);
		ahb(1'b0, {24'h0, pmf_pkg::A_STAT}, 32'h0);
		chk("store done", r, 32'h1);
		ahb(1'b1, {24'h0, pmf_pkg::A_STAT}, 32'h1);
		ahb(1'b0, {24'h0, pmf_pkg::A_STAT}, 32'h0);
		chk("store done cleared", r, 32'h0);
		ara();
		chk("no alert ack", 32'(ack), 0);
		ahb(1'b1, {24'h0, pmf_pkg::A_CTRL}, 32'h1);
		repeat (30) @(posedge hclk);
		chk("alert line", 32'(alert_n), 0);
		ara();
		chk("alert ack", 32'(ack), 1);
		chk("alert source", 32'(d), 32'({SADDR, 1'b0}));
		chk("alert released", 32'(alert_n), 1);
		ahb(1'b1, {24'h0, pmf_pkg::A_CTRL}, 32'h0);
		host.h = 42;
		lwr(pmf_pkg::C_OCF, 16'hf848, 2, 0);
		chk("fast write", 32'(ocf), 32'hf848);
		host.h = 166;
		lwr(pmf_pkg::C_OCW, 16'hf838, 2, 1);
		host.h = 8;
		chk("standard write", 32'(ocw), 32'hf838);
		chk("clock never driven", n_str, 0);
		hresetn <= 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (20) @(posedge hclk);
		foreach (dflt[i]) begin
			ahb(1'b0, 32'h8 + 4 * i, 32'h0);
			chk("default", r, dflt[i]);
		end
		ahb(1'b0, 32'h18, 32'h0);
		chk("unmapped", r, 0);
		print_verdict();
	end
endmodule
`default_nettype wire
